// [hw/phy_resp_regs.vh]
// Constants shared by the physical layer request responder.
`ifndef PHY_RESP_REGS_VH
`define PHY_RESP_REGS_VH
// Request opcodes on REQ_OP_I.
`define OP_NOISE   3'h0
`define OP_SNR     3'h1
`define OP_ZCROSS  3'h2
`define OP_CCA     3'h3
`define OP_CH_SET  3'h4
`define OP_CH_GET  3'h5
`define OP_RESET   3'h6
`define OP_SLEEP   3'h7
// Widths.
`define DESC_W     8
`define TIME_W     20
`define DATA_W     20
// Medium descriptor bit that marks a radio medium.
`define DESC_RF_BIT 7
// Descriptor reset value.
`define DESC_RST   8'h00
// Result codes.
`define RES_OK     2'h0
`define RES_FAIL   2'h1
`define RES_ASLEEP 2'h2
// Noise level scale: dBuV for power line, negative dBm for radio.
`define NL_PLC_BASE 8'h32
`define NL_RF_BASE  8'h6B
`define NL_STEP     8'h03
`define NL_MAX_CODE 4'hF
// Signal to noise scale in dB.
`define SNR_BASE    8'h00
`define SNR_STEP    8'h03
`define SNR_MAX     3'h7
// Timestamp tick: 10 us at 40 ns clock.
`define TICK_NS     10000
`define CLK_NS      40
`define TICK_CYC    (`TICK_NS / `CLK_NS)
`define TICK_CNT_W  9
`endif

// [hw/level_quantizer.v]
// Maps a level above a floor to a step code with saturation.
`timescale 1ns/1ps
`include "phy_resp_regs.vh"
module level_quantizer
#(
  parameter CODE_W = 4
)
(
  input  wire [7:0]        level_i,
  input  wire [7:0]        base_i,
  input  wire [7:0]        step_i,
  input  wire              invert_i,
  output reg  [CODE_W-1:0] code_o
);
  reg [7:0] diff;
  reg [8:0] lim;
  integer   k;

  // Code k covers up to base+k*step; the top code means above the last.
  // Radio noise is given as a magnitude in dBm, so a larger value is
  // quieter and the comparison is turned round.
  always @*
  begin
    diff   = 8'h00;
    lim    = 9'h000;
    code_o = {CODE_W{1'b1}};
    if (invert_i)
      diff = (level_i >= base_i) ? 8'h00 : base_i - level_i;
    else
      diff = (level_i <= base_i) ? 8'h00 : level_i - base_i;
    for (k = (1 << CODE_W) - 2; k >= 0; k = k - 1)
    begin
      lim = k[8:0] * {1'b0, step_i};
      if ({1'b0, diff} <= lim)
        code_o = k[CODE_W-1:0];
    end
  end
endmodule

// [hw/tick_timer.v]
// Free-running 20-bit timebase counting in steps of ten microseconds.
`timescale 1ns/1ps
`include "phy_resp_regs.vh"
module tick_timer
(
  input  wire               clk_i,
  input  wire               resetn_i,
  input  wire               clear_i,
  output reg  [`TIME_W-1:0] time_o
);
  reg [`TICK_CNT_W-1:0] pre_q;

  // Prescaler divides the clock down to one tick each 10 us.
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre_q  <= {`TICK_CNT_W{1'b0}};
      time_o <= {`TIME_W{1'b0}};
    end
    else if (clear_i)
    begin
      pre_q  <= {`TICK_CNT_W{1'b0}};
      time_o <= {`TIME_W{1'b0}};
    end
    else if (pre_q == `TICK_CYC - 1)
    begin
      pre_q  <= {`TICK_CNT_W{1'b0}};
      time_o <= time_o + 1'b1;
    end
    else
      pre_q <= pre_q + 1'b1;
  end
endmodule

// [hw/phy_service_primitive_responder.v]
// Responder for control and management requests from the MAC controller.
`timescale 1ns/1ps
`include "phy_resp_regs.vh"
module phy_service_primitive_responder
(
  input  wire               CLK_I,
  input  wire               RESETN_I,
  input  wire               REQ_VALID_I,
  input  wire [2:0]         REQ_OP_I,
  input  wire [`DESC_W-1:0] REQ_DESC_I,
  input  wire               MGMT_ENABLE_I,
  input  wire [7:0]         NOISE_LEVEL_I,
  input  wire [7:0]         FRAME_SIGNAL_I,
  input  wire [7:0]         FRAME_NOISE_I,
  input  wire               FRAME_END_I,
  input  wire               ZERO_CROSS_I,
  input  wire               LINK_ACTIVITY_I,
  input  wire [7:0]         ENERGY_I,
  input  wire [15:0]        ASSESS_DURATION_I,
  input  wire [7:0]         ASSESS_THRESHOLD_I,
  input  wire               TX_BUSY_I,
  input  wire               INTERNAL_FAULT_I,
  output reg                CNF_VALID_O,
  output reg  [2:0]         CNF_OP_O,
  output reg  [1:0]         CNF_RESULT_O,
  output reg  [`DATA_W-1:0] CNF_DATA_O,
  output reg  [`TIME_W-1:0] CNF_ELAPSED_O,
  output reg  [`DESC_W-1:0] CNF_DESC_O,
  output reg  [`DESC_W-1:0] MEDIUM_DESC_O,
  output reg                RX_ENABLE_O,
  output reg                SLEEP_O,
  output reg                FLUSH_O
);
  // One-hot states.
  localparam ST_IDLE  = 4'h1;
  localparam ST_CCA   = 4'h2;
  localparam ST_SLEEP = 4'h4;
  localparam ST_ANSW  = 4'h8;

  reg  [3:0]         state_q;
  reg  [2:0]         op_q;
  reg  [`DESC_W-1:0] desc_q;
  reg  [7:0]         snr_q;
  reg  [`TIME_W-1:0] zc_time_q;
  reg  [`TIME_W-1:0] act_time_q;
  reg  [`TIME_W-1:0] gap_q;
  reg  [15:0]        cca_cnt_q;
  reg                cca_busy_q;
  reg  [1:0]         res_q;
  reg                asleep_q;
  reg  [1:0]         zc_sync_q;
  reg                zc_hist_q;
  reg  [1:0]         fe_sync_q;
  reg                fe_prev_q;
  reg  [1:0]         act_sync_q;
  reg                act_prev_q;
  reg  [1:0]         fault_sync_q;
  reg  [1:0]         tx_sync_q;
  wire [`TIME_W-1:0] now;
  wire [3:0]         noise_code;
  wire [2:0]         snr_code;
  wire               rf_medium;
  wire               zc_edge;
  wire               fe_edge;
  wire               act_edge;
  wire               req_take;

  assign rf_medium = desc_q[`DESC_RF_BIT];
  assign zc_edge   = zc_sync_q[1] & ~zc_hist_q;
  assign fe_edge   = fe_sync_q[1] & ~fe_prev_q;
  assign act_edge  = act_sync_q[1] & ~act_prev_q;
  assign req_take  = REQ_VALID_I & state_q[0];

  // Shared timebase; a management reset restarts it as well.
  tick_timer u_timer
  (
    .clk_i    (CLK_I),
    .resetn_i (RESETN_I),
    .clear_i  (FLUSH_O),
    .time_o   (now)
  );

  // Noise level code; medium type picks the scale.
  level_quantizer #(.CODE_W(4)) u_noise_q
  (
    .level_i  (NOISE_LEVEL_I),
    .base_i   (rf_medium ? `NL_RF_BASE : `NL_PLC_BASE),
    .step_i   (`NL_STEP),
    .invert_i (rf_medium),
    .code_o   (noise_code)
  );

  // Signal to noise code from the last frame's captured ratio.
  level_quantizer #(.CODE_W(3)) u_snr_q
  (
    .level_i  (snr_q),
    .base_i   (`SNR_BASE),
    .step_i   (`SNR_STEP),
    .invert_i (1'b0),
    .code_o   (snr_code)
  );

  // Zero cross, frame end, link activity, fault and transmit busy pins pass two flip-flops before use.
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      zc_sync_q    <= 2'h0;
      zc_hist_q    <= 1'b0;
      fe_sync_q    <= 2'h0;
      fe_prev_q    <= 1'b0;
      act_sync_q   <= 2'h0;
      act_prev_q   <= 1'b0;
      fault_sync_q <= 2'h0;
      tx_sync_q    <= 2'h0;
    end
    else
    begin
      zc_sync_q    <= {zc_sync_q[0], ZERO_CROSS_I};
      zc_hist_q    <= zc_sync_q[1];
      fe_sync_q    <= {fe_sync_q[0], FRAME_END_I};
      fe_prev_q    <= fe_sync_q[1];
      act_sync_q   <= {act_sync_q[0], LINK_ACTIVITY_I};
      act_prev_q   <= act_sync_q[1];
      fault_sync_q <= {fault_sync_q[0], INTERNAL_FAULT_I};
      tx_sync_q    <= {tx_sync_q[0], TX_BUSY_I};
    end
  end

  // Measurement capture. SNR is latched once per received frame, not
  // averaged, so a query always reflects the latest frame alone.
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      snr_q      <= 8'h00;
      zc_time_q  <= {`TIME_W{1'b0}};
      act_time_q <= {`TIME_W{1'b0}};
      gap_q      <= {`TIME_W{1'b0}};
    end
    else if (FLUSH_O)
    begin
      snr_q      <= 8'h00;
      zc_time_q  <= {`TIME_W{1'b0}};
      act_time_q <= {`TIME_W{1'b0}};
      gap_q      <= {`TIME_W{1'b0}};
    end
    else
    begin
      if (fe_edge)
        snr_q <= (FRAME_SIGNAL_I > FRAME_NOISE_I) ?
                 FRAME_SIGNAL_I - FRAME_NOISE_I : 8'h00;
      if (act_edge)
        act_time_q <= now;
      if (zc_edge)
      begin
        zc_time_q <= now;
        gap_q     <= now - act_time_q;
      end
    end
  end

  // Request sequencer and confirm generation.
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      state_q       <= ST_IDLE;
      op_q          <= 3'h0;
      desc_q        <= `DESC_RST;
      cca_cnt_q     <= 16'h0000;
      cca_busy_q    <= 1'b0;
      res_q         <= `RES_OK;
      asleep_q      <= 1'b0;
      CNF_VALID_O   <= 1'b0;
      CNF_OP_O      <= 3'h0;
      CNF_RESULT_O  <= `RES_OK;
      CNF_DATA_O    <= {`DATA_W{1'b0}};
      CNF_ELAPSED_O <= {`TIME_W{1'b0}};
      CNF_DESC_O    <= `DESC_RST;
      MEDIUM_DESC_O <= `DESC_RST;
      RX_ENABLE_O   <= 1'b1;
      SLEEP_O       <= 1'b0;
      FLUSH_O       <= 1'b0;
    end
    else
    begin
      CNF_VALID_O   <= 1'b0;
      FLUSH_O       <= 1'b0;
      MEDIUM_DESC_O <= desc_q;
      RX_ENABLE_O   <= ~asleep_q & ~state_q[2];
      SLEEP_O       <= asleep_q;
      case (state_q)
        ST_IDLE:
        begin
          if (req_take)
          begin
            op_q  <= REQ_OP_I;
            res_q <= `RES_OK;
            if (REQ_OP_I == `OP_CCA)
            begin
              cca_cnt_q  <= ASSESS_DURATION_I;
              cca_busy_q <= 1'b0;
              state_q    <= ST_CCA;
            end
            else if (REQ_OP_I == `OP_CH_SET)
            begin
              desc_q  <= REQ_DESC_I;
              state_q <= ST_ANSW;
            end
            else if (REQ_OP_I == `OP_RESET)
            begin
              if (!MGMT_ENABLE_I)
                res_q <= `RES_FAIL;
              else if (fault_sync_q[1])
                res_q <= `RES_FAIL;
              else
              begin
                FLUSH_O  <= 1'b1;
                asleep_q <= 1'b0;
                desc_q   <= `DESC_RST;
              end
              state_q <= ST_ANSW;
            end
            else if (REQ_OP_I == `OP_SLEEP)
            begin
              if (!MGMT_ENABLE_I || fault_sync_q[1])
              begin
                res_q   <= `RES_FAIL;
                state_q <= ST_ANSW;
              end
              else if (asleep_q)
              begin
                res_q   <= `RES_ASLEEP;
                state_q <= ST_ANSW;
              end
              else
                state_q <= ST_SLEEP;
            end
            else
              state_q <= ST_ANSW;
          end
        end
        ST_CCA:
        begin
          // Energy detection: any sample above threshold marks busy.
          if (ENERGY_I > ASSESS_THRESHOLD_I)
            cca_busy_q <= 1'b1;
          if (cca_cnt_q == 16'h0000)
            state_q <= ST_ANSW;
          else
            cca_cnt_q <= cca_cnt_q - 16'h0001;
        end
        ST_SLEEP:
        begin
          // Reception goes off at the first clock in this state; wait for transmit to drain.
          if (!tx_sync_q[1])
          begin
            asleep_q <= 1'b1;
            state_q  <= ST_ANSW;
          end
        end
        ST_ANSW:
        begin
          CNF_VALID_O   <= 1'b1;
          CNF_OP_O      <= op_q;
          CNF_RESULT_O  <= res_q;
          CNF_DESC_O    <= desc_q;
          CNF_ELAPSED_O <= {`TIME_W{1'b0}};
          CNF_DATA_O    <= {`DATA_W{1'b0}};
          if (op_q == `OP_NOISE)
            CNF_DATA_O <= {16'h0000, noise_code};
          else if (op_q == `OP_SNR)
            CNF_DATA_O <= {17'h00000, snr_code};
          else if (op_q == `OP_ZCROSS)
          begin
            CNF_DATA_O    <= zc_time_q;
            CNF_ELAPSED_O <= gap_q;
          end
          else if (op_q == `OP_CCA)
            CNF_DATA_O <= {19'h00000, ~cca_busy_q};
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// [bench/phy_resp_asserts.sv]
// Port-level checks on the physical layer request responder.
`timescale 1ns/1ps
module phy_resp_asserts
(
  input wire        CLK_I,
  input wire        RESETN_I,
  input wire        REQ_VALID_I,
  input wire [2:0]  REQ_OP_I,
  input wire [7:0]  REQ_DESC_I,
  input wire        MGMT_ENABLE_I,
  input wire        CNF_VALID_O,
  input wire [2:0]  CNF_OP_O,
  input wire [1:0]  CNF_RESULT_O,
  input wire [19:0] CNF_DATA_O,
  input wire [7:0]  CNF_DESC_O,
  input wire [7:0]  MEDIUM_DESC_O,
  input wire        RX_ENABLE_O,
  input wire        SLEEP_O
);
  reg [2:0] op_q;
  reg       busy_q;
  wire      take;
  assign take = REQ_VALID_I && (!busy_q || CNF_VALID_O);
  // Follow the one outstanding request, since later strobes are dropped.
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      busy_q <= 1'b0;
      op_q   <= 3'h0;
    end
    else if (take)
    begin
      busy_q <= 1'b1;
      op_q   <= REQ_OP_I;
    end
    else if (CNF_VALID_O)
      busy_q <= 1'b0;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  chk_cnf_pulse: assert property (CNF_VALID_O |=> !CNF_VALID_O)
    else $error("confirm strobe lasted more than one cycle");
  chk_fast_answer: assert property (take && REQ_OP_I != 3'h3 &&
    REQ_OP_I != 3'h7 |=> !CNF_VALID_O ##1 CNF_VALID_O)
    else $error("confirm not two cycles after request");
  chk_op_echo: assert property (CNF_VALID_O |-> CNF_OP_O == op_q)
    else $error("confirm opcode differs from request");
  chk_desc_echo: assert property (take && REQ_OP_I == 3'h4 |->
    ##2 CNF_DESC_O == $past(REQ_DESC_I, 2))
    else $error("channel confirm lacks new descriptor");
  chk_medium_set: assert property (take && REQ_OP_I == 3'h4 |->
    ##3 MEDIUM_DESC_O == $past(REQ_DESC_I, 3))
    else $error("medium not switched");
  chk_mgmt_off: assert property (take && REQ_OP_I == 3'h6 &&
    !MGMT_ENABLE_I |-> ##2 CNF_RESULT_O == 2'h1)
    else $error("disabled reset did not fail");
  chk_sleep_rx: assert property (SLEEP_O |-> !RX_ENABLE_O)
    else $error("reception enabled while asleep");
  chk_snr_width: assert property (CNF_VALID_O && CNF_OP_O == 3'h1
    |-> CNF_DATA_O[19:3] == 17'h0)
    else $error("signal to noise index too wide");
  chk_noise_width: assert property (CNF_VALID_O && CNF_OP_O == 3'h0
    |-> CNF_DATA_O[19:4] == 16'h0)
    else $error("noise code too wide");
  chk_cca_flag: assert property (CNF_VALID_O && CNF_OP_O == 3'h3
    |-> CNF_DATA_O[19:1] == 19'h0)
    else $error("channel flag too wide");
  chk_sleep_code: assert property (CNF_VALID_O && CNF_OP_O == 3'h7
    |-> CNF_RESULT_O != 2'h3)
    else $error("sleep result out of range");
endmodule

// [bench/mac_ctrl_model.sv]
// Model of the link controller that issues requests and awaits confirms.
`timescale 1ns/1ps
module mac_ctrl_model
(
  input  wire       clk_i,
  input  wire       cnf_valid_i,
  output reg        req_valid_o,
  output reg  [2:0] req_op_o,
  output reg  [7:0] req_desc_o
);
  integer waited;
  // Idle lines at start so no request is seen during reset.
  initial
  begin
    req_valid_o = 1'b0;
    req_op_o    = 3'h0;
    req_desc_o  = 8'h00;
  end
  // One strobe, then wait for its confirm before anything else is sent.
  task issue(input [2:0] op, input [7:0] desc);
  begin
    @(negedge clk_i);
    req_valid_o <= 1'b1;
    req_op_o    <= op;
    req_desc_o  <= desc;
    @(negedge clk_i);
    req_valid_o <= 1'b0;
    req_op_o    <= ~op;
    req_desc_o  <= ~desc;
    waited = 0;
    while (cnf_valid_i !== 1'b1 && waited < 2000)
    begin
      @(negedge clk_i);
      waited = waited + 1;
    end
  end
  endtask
endmodule

// [bench/phy_service_primitive_responder_test.sv]
// Self-checking bench for the physical layer request responder.
`timescale 1ns/1ps
module phy_service_primitive_responder_test;
  reg         clk, resetn, mgmt_en, f_end, zc, act, tx_busy, fault, seen_fl;
  reg  [7:0]  noise, f_sig, f_noise, energy, thr, lvl, desc_r;
  reg  [15:0] dur;
  reg  [2:0]  op_r;
  reg  [19:0] exp_r;
  reg  [38:0] rows [0:12];
  wire        req_v, cnf_v, rx_en, sleep, flush;
  wire [2:0]  req_op, cnf_op;
  wire [7:0]  req_desc, cnf_desc, med_desc;
  wire [1:0]  cnf_res;
  wire [19:0] cnf_data, cnf_el;
  integer     fail_count = 0;
  integer     samples_checked = 0;
  integer     i;
  phy_service_primitive_responder u_dut (.CLK_I(clk), .RESETN_I(resetn),
    .REQ_VALID_I(req_v), .REQ_OP_I(req_op), .REQ_DESC_I(req_desc),
    .MGMT_ENABLE_I(mgmt_en), .NOISE_LEVEL_I(noise), .FRAME_SIGNAL_I(f_sig),
    .FRAME_NOISE_I(f_noise), .FRAME_END_I(f_end), .ZERO_CROSS_I(zc),
    .LINK_ACTIVITY_I(act), .ENERGY_I(energy), .ASSESS_DURATION_I(dur),
    .ASSESS_THRESHOLD_I(thr), .TX_BUSY_I(tx_busy), .INTERNAL_FAULT_I(fault),
    .CNF_VALID_O(cnf_v), .CNF_OP_O(cnf_op), .CNF_RESULT_O(cnf_res),
    .CNF_DATA_O(cnf_data), .CNF_ELAPSED_O(cnf_el), .CNF_DESC_O(cnf_desc),
    .MEDIUM_DESC_O(med_desc), .RX_ENABLE_O(rx_en), .SLEEP_O(sleep),
    .FLUSH_O(flush));
  mac_ctrl_model u_mac (.clk_i(clk), .cnf_valid_i(cnf_v), .req_valid_o(req_v),
    .req_op_o(req_op), .req_desc_o(req_desc));
  task check(input string what, input [19:0] exp, input [19:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  end
  endtask
  task test_done;
  begin
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // A request must be answered and echo its opcode.
  task req(input [2:0] op, input [7:0] desc);
  begin
    u_mac.issue(op, desc);
    check("confirm", 20'h00001, {19'h0, cnf_v});
    check("opcode", {17'h0, op}, {17'h0, cnf_op});
  end
  endtask
  // Frame levels are held until the synchronised edge has been taken.
  task frame(input [7:0] s, input [7:0] n, input [2:0] code);
  begin
    f_sig = s;
    f_noise = n;
    f_end = 1'b1;
    repeat (4) @(negedge clk);
    f_end = 1'b0;
    repeat (4) @(negedge clk);
    req(3'h1, 8'h00);
    check("snr", {17'h0, code}, cnf_data);
  end
  endtask
  // Free-running clock at 25 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The reset flush is a pulse, so it is caught here.
  always @(posedge clk)
    if (flush === 1'b1)
      seen_fl = 1'b1;
  // Cuts a hang short with a generous margin over the whole sequence.
  initial
  begin
    #(40 * 8000);
    fail_count = fail_count + 1;
    test_done;
  end
  // Rows hold opcode, descriptor, input level and expected answer.
  initial
  begin
    {resetn, f_end, zc, act, tx_busy, fault, seen_fl} = 7'h00;
    {noise, f_sig, f_noise, energy} = 32'h0;
    mgmt_en = 1'b1;
    dur = 16'h0004;
    thr = 8'h40;
    rows[0]  = {3'h4, 8'h00, 8'h00, 20'h00000};
    rows[1]  = {3'h0, 8'h00, 8'h32, 20'h00000};
    rows[2]  = {3'h0, 8'h00, 8'h33, 20'h00001};
    rows[3]  = {3'h0, 8'h00, 8'h5C, 20'h0000E};
    rows[4]  = {3'h0, 8'h00, 8'h5D, 20'h0000F};
    rows[5]  = {3'h4, 8'h81, 8'h00, 20'h00081};
    rows[6]  = {3'h5, 8'h00, 8'h00, 20'h00081};
    rows[7]  = {3'h0, 8'h00, 8'h6B, 20'h00000};
    rows[8]  = {3'h0, 8'h00, 8'h69, 20'h00001};
    rows[9]  = {3'h0, 8'h00, 8'h41, 20'h0000E};
    rows[10] = {3'h0, 8'h00, 8'h40, 20'h0000F};
    rows[11] = {3'h3, 8'h00, 8'h40, 20'h00001};
    rows[12] = {3'h3, 8'h00, 8'h41, 20'h00000};
    repeat (2) @(negedge clk);
    check("reset state", 20'h00100,
          {8'h0, cnf_v, sleep, flush, rx_en, med_desc});
    resetn = 1'b1;
    for (i = 0; i < 13; i = i + 1)
    begin
      {op_r, desc_r, lvl, exp_r} = rows[i];
      noise = lvl;
      energy = lvl;
      req(op_r, desc_r);
      check("answer", exp_r, op_r[2] ? {12'h0, cnf_desc} : cnf_data);
    end
    check("medium", 20'h00081, {12'h0, med_desc});
    $display("table test done");
    frame(8'h28, 8'h24, 3'h2);
    frame(8'h1E, 8'h28, 3'h0);
    frame(8'h3A, 8'h28, 3'h6);
    f_sig = 8'hFF;
    req(3'h1, 8'h00);
    check("snr held", 20'h00006, cnf_data);
    $display("snr test done");
    req(3'h6, 8'h00);
    check("reset result", 20'h0, {18'h0, cnf_res});
    check("flushed", 20'h1, {19'h0, seen_fl});
    req(3'h5, 8'h00);
    check("desc cleared", 20'h0, {12'h0, cnf_desc});
    repeat (370) @(negedge clk);
    act = 1'b1;
    repeat (4) @(negedge clk);
    act = 1'b0;
    repeat (746) @(negedge clk);
    zc = 1'b1;
    repeat (4) @(negedge clk);
    zc = 1'b0;
    repeat (4) @(negedge clk);
    req(3'h2, 8'h00);
    check("zero cross", 20'h00004, cnf_data);
    check("elapsed", 20'h00003, cnf_el);
    $display("timing test done");
    mgmt_en = 1'b0;
    req(3'h6, 8'h00);
    check("disabled", 20'h1, {18'h0, cnf_res});
    mgmt_en = 1'b1;
    fault = 1'b1;
    // The fault pin passes two flip-flops, so let it settle first.
    repeat (3) @(negedge clk);
    req(3'h7, 8'h00);
    check("sleep fault", 20'h1, {18'h0, cnf_res});
    fault = 1'b0;
    repeat (3) @(negedge clk);
    tx_busy = 1'b1;
    fork
      req(3'h7, 8'h00);
      begin
        repeat (12) @(negedge clk);
        check("rx off", 20'h0, {19'h0, rx_en});
        check("early sleep", 20'h0, {19'h0, sleep});
        tx_busy = 1'b0;
      end
    join
    check("sleep result", 20'h0, {18'h0, cnf_res});
    check("asleep", 20'h1, {19'h0, sleep});
    req(3'h7, 8'h00);
    check("again", 20'h2, {18'h0, cnf_res});
    req(3'h6, 8'h00);
    check("awake", 20'h1, {19'h0, rx_en});
    $display("management test done");
    test_done;
  end
endmodule
bind phy_service_primitive_responder phy_resp_asserts u_chk (.CLK_I(CLK_I),
  .RESETN_I(RESETN_I), .REQ_VALID_I(REQ_VALID_I), .REQ_OP_I(REQ_OP_I),
  .REQ_DESC_I(REQ_DESC_I), .MGMT_ENABLE_I(MGMT_ENABLE_I),
  .CNF_VALID_O(CNF_VALID_O), .CNF_OP_O(CNF_OP_O),
  .CNF_RESULT_O(CNF_RESULT_O), .CNF_DATA_O(CNF_DATA_O),
  .CNF_DESC_O(CNF_DESC_O), .MEDIUM_DESC_O(MEDIUM_DESC_O),
  .RX_ENABLE_O(RX_ENABLE_O), .SLEEP_O(SLEEP_O));
